// ### verilog/timer16_pkg.sv
package timer16_pkg;

  // ****************************************************************
  // Register addresses
  // ****************************************************************
  localparam logic [15:0] ADDR_CLK_SEL    = 16'hff40;
  localparam logic [15:0] ADDR_MODE_CTRL  = 16'hff48;
  localparam logic [15:0] ADDR_CC_CTRL    = 16'hff4c;
  localparam logic [15:0] ADDR_FIRST_CC   = 16'hff10;
  localparam logic [15:0] ADDR_SECOND_CC  = 16'hff12;
  localparam logic [15:0] ADDR_COUNTER    = 16'hff14;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0]  CLK_SEL_RST     = 8'h00;
  localparam logic [2:0]  MODE_RST        = 3'h0;
  localparam logic        OVF_RST         = 1'b0;
  localparam logic [2:0]  CC_CTRL_RST     = 3'h4;
  localparam logic [15:0] COUNTER_RST     = 16'h0000;
  localparam logic [15:0] CC_RST          = 16'h0000;
  localparam logic [7:0]  DIV_RST         = 8'h00;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int OVF_BIT          = 0;
  localparam int MODE_LSB         = 1;
  localparam int MODE_MSB         = 3;
  localparam int FIRST_SEL_BIT    = 0;
  localparam int FIRST_TRIG_BIT   = 1;
  localparam int SECOND_SEL_BIT   = 2;
  localparam int CNT_SRC_LSB      = 4;
  localparam int CNT_SRC_MSB      = 6;
  localparam int CLKOUT_SRC_MSB   = 3;
  localparam int CLKOUT_EN_BIT    = 7;

  // ****************************************************************
  // Counts and codes
  // ****************************************************************
  localparam logic [15:0] COUNTER_MAX     = 16'hffff;
  localparam logic [3:0]  CLKOUT_SUB      = 4'h0;
  localparam logic [3:0]  CLKOUT_DIV_FIRST = 4'h5;
  localparam logic [3:0]  CLKOUT_DIV_LAST = 4'hc;
  localparam int          DIV_W           = 8;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    MODE_STOP      = 3'b000,
    MODE_PWM       = 3'b001,
    MODE_MATCH_OUT = 3'b010,
    MODE_FREE      = 3'b011,
    MODE_FREE_ALT  = 3'b100,
    MODE_CLR_EDGE  = 3'b101,
    MODE_CLR_MATCH = 3'b110,
    MODE_CLR_MATCH_ALT = 3'b111
  } mode_e;

  typedef enum logic [2:0] {
    CNT_PIN    = 3'b000,
    CNT_2FXX   = 3'b001,
    CNT_FXX    = 3'b010,
    CNT_FXX_D2 = 3'b011,
    CNT_FXX_D4 = 3'b100,
    CNT_WATCH  = 3'b111
  } cnt_src_e;

  typedef enum logic [1:0] {
    EDGE_FALL = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_BAD  = 2'b10,
    EDGE_BOTH = 2'b11
  } edge_e;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
    logic        wide;
  } cpu_req_s;

  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } pin_edge_s;

endpackage : timer16_pkg

// ### verilog/pin_edge_sync.sv
`timescale 1ns/100ps
`default_nettype none

module pin_edge_sync (
  input  wire logic                    CLOCK,
  input  wire logic                    RST,
  input  wire logic                    PIN,
  output var  timer16_pkg::pin_edge_s  EDGES
);
  import timer16_pkg::*;

  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } sync_s;

  sync_s q_ff;
  sync_s nxt_q;

  // ****************************************************************
  // Two flops against metastability, a third for edge detection
  // ****************************************************************
  always_comb begin
    nxt_q      = q_ff;
    nxt_q.meta = PIN;
    nxt_q.sync = q_ff.meta;
    nxt_q.last = q_ff.sync;
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign EDGES.level = q_ff.sync;
  assign EDGES.rise  = q_ff.sync & ~q_ff.last;
  assign EDGES.fall  = ~q_ff.sync & q_ff.last;

endmodule : pin_edge_sync

`default_nettype wire

// ### verilog/fxx_prescaler.sv
`timescale 1ns/100ps
`default_nettype none

module fxx_prescaler (
  input  wire logic                          CLOCK,
  input  wire logic                          RST,
  output logic [timer16_pkg::DIV_W-1:0]      DIV
);
  import timer16_pkg::*;

  logic [DIV_W-1:0] div_ff;
  logic [DIV_W-1:0] nxt_div;

  // ****************************************************************
  // Free divider; bit k is a square wave at fxx/2^k
  // ****************************************************************
  always_comb begin
    nxt_div = div_ff + 8'h01;
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      div_ff <= DIV_RST;
    end else begin
      div_ff <= nxt_div;
    end
  end

  assign DIV = div_ff;

endmodule : fxx_prescaler

`default_nettype wire

// ### verilog/timer16_core.sv
`timescale 1ns/100ps
`default_nettype none

module timer16_core (
  input  wire logic                    CLOCK,
  input  wire logic                    RST,
  input  wire timer16_pkg::cpu_req_s   BUS_REQ,
  output logic [15:0]                  BUS_RDATA,
  input  wire logic                    PRIMARY_TIMER_INPUT,
  input  wire logic                    SECONDARY_TIMER_INPUT,
  input  wire logic                    SUBSYSTEM_CLOCK,
  input  wire logic                    WATCH_TICK_SOURCE,
  input  wire logic [1:0]              EDGE_SEL_PIN0,
  input  wire logic [1:0]              EDGE_SEL_PIN1,
  output logic                         FIRST_MATCH_IRQ,
  output logic                         SECOND_MATCH_IRQ,
  output logic                         PROGRAMMABLE_CLOCK_OUT
);
  import timer16_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef enum logic [1:0] {
    RUN_IDLE  = 2'b00,
    RUN_ARMED = 2'b01,
    RUN_COUNT = 2'b10
  } run_e;

  typedef struct packed {
    logic [7:0]  clk_sel;
    mode_e       mode;
    logic        ovf;
    logic [2:0]  cc_ctrl;
    logic [15:0] cr0;
    logic [15:0] cr1;
    logic [15:0] cnt;
    run_e        run;
    logic        eq0_prev;
    logic        eq1_prev;
    logic        irq0;
    logic        irq1;
    logic [15:0] rdata;
    logic        clkout;
  } core_s;

  core_s q_ff;
  core_s nxt_q;

  pin_edge_s          pin0;
  pin_edge_s          pin1;
  pin_edge_s          sub;
  logic [DIV_W-1:0]   div;

  // ****************************************************************
  // Pin synchronisers and divider
  // ****************************************************************
  pin_edge_sync u_pin0 (
    .CLOCK (CLOCK),
    .RST   (RST),
    .PIN   (PRIMARY_TIMER_INPUT),
    .EDGES (pin0)
  );

  pin_edge_sync u_pin1 (
    .CLOCK (CLOCK),
    .RST   (RST),
    .PIN   (SECONDARY_TIMER_INPUT),
    .EDGES (pin1)
  );

  pin_edge_sync u_sub (
    .CLOCK (CLOCK),
    .RST   (RST),
    .PIN   (SUBSYSTEM_CLOCK),
    .EDGES (sub)
  );

  fxx_prescaler u_div (
    .CLOCK (CLOCK),
    .RST   (RST),
    .DIV   (div)
  );

  // ****************************************************************
  // Edge decoding
  // ****************************************************************
  logic       valid0;
  logic       valid1;
  logic       cap0_pin0;
  logic       tick;
  logic       running;
  logic       clr_match;
  logic       first_cmp;
  logic       second_cmp;
  logic       eq0;
  logic       eq1;
  logic       trig0;
  logic       wrap;
  logic [2:0] out_idx;
  logic       out_src;

  function automatic logic valid_edge(input logic [1:0] sel,
                                      input pin_edge_s  e);
    logic v;
    v = 1'b0;
    case (edge_e'(sel))
      EDGE_FALL: v = e.fall;
      EDGE_RISE: v = e.rise;
      EDGE_BOTH: v = e.rise | e.fall;
      default:   v = 1'b0;
    endcase
    return v;
  endfunction : valid_edge

  always_comb begin
    valid0 = valid_edge(EDGE_SEL_PIN0, pin0);
    valid1 = valid_edge(EDGE_SEL_PIN1, pin1);
    // Capture edge is the opposite of the pin's single valid edge; both-edge selection captures nothing
    case (edge_e'(EDGE_SEL_PIN0))
      EDGE_FALL: cap0_pin0 = pin0.rise;
      EDGE_RISE: cap0_pin0 = pin0.fall;
      default:   cap0_pin0 = 1'b0;
    endcase
  end

  // ****************************************************************
  // Count clock selection
  // ****************************************************************
  // Doubled clock is modelled as every CLOCK edge, so fxx is CLOCK/2;
  // software must keep it out of use at high clock rates.
  always_comb begin
    case (cnt_src_e'(q_ff.clk_sel[CNT_SRC_MSB:CNT_SRC_LSB]))
      CNT_PIN:    tick = valid0;
      CNT_2FXX:   tick = 1'b1;
      CNT_FXX:    tick = div[0];
      CNT_FXX_D2: tick = &div[1:0];
      CNT_FXX_D4: tick = &div[2:0];
      CNT_WATCH:  tick = WATCH_TICK_SOURCE;
      default:    tick = 1'b0;
    endcase
  end

  // ****************************************************************
  // Clock output selection
  // ****************************************************************
  always_comb begin
    out_idx = 3'(q_ff.clk_sel[CLKOUT_SRC_MSB:0] - CLKOUT_DIV_FIRST);
    if (q_ff.clk_sel[CLKOUT_SRC_MSB:0] == CLKOUT_SUB) begin
      out_src = sub.level;
    end else if (q_ff.clk_sel[CLKOUT_SRC_MSB:0] >= CLKOUT_DIV_FIRST &&
                 q_ff.clk_sel[CLKOUT_SRC_MSB:0] <= CLKOUT_DIV_LAST) begin
      out_src = div[out_idx];
    end else begin
      out_src = 1'b0;
    end
  end

  // ****************************************************************
  // Compare and mode decode
  // ****************************************************************
  always_comb begin
    running    = (q_ff.mode != MODE_STOP);
    first_cmp  = ~q_ff.cc_ctrl[FIRST_SEL_BIT];
    second_cmp = ~q_ff.cc_ctrl[SECOND_SEL_BIT];
    case (q_ff.mode)
      MODE_CLR_MATCH:     clr_match = first_cmp;
      MODE_CLR_MATCH_ALT: clr_match = first_cmp;
      default:            clr_match = 1'b0;
    endcase
    eq0   = running & first_cmp & (q_ff.cnt == q_ff.cr0);
    eq1   = running & second_cmp & (q_ff.cnt == q_ff.cr1);
    trig0 = q_ff.cc_ctrl[FIRST_TRIG_BIT] ? valid1 : cap0_pin0;
    wrap  = q_ff.cnt == COUNTER_MAX;
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    nxt_q       = q_ff;
    nxt_q.irq0  = 1'b0;
    nxt_q.irq1  = 1'b0;

    // Register writes come first so that hardware events below win
    if (BUS_REQ.wr) begin
      case (BUS_REQ.addr)
        ADDR_CLK_SEL: begin
          nxt_q.clk_sel = BUS_REQ.wdata[7:0];
        end
        ADDR_MODE_CTRL: begin
          nxt_q.mode = mode_e'(BUS_REQ.wdata[MODE_MSB:MODE_LSB]);
          nxt_q.ovf  = BUS_REQ.wdata[OVF_BIT];
        end
        ADDR_CC_CTRL: begin
          nxt_q.cc_ctrl = BUS_REQ.wdata[2:0];
        end
        ADDR_FIRST_CC: begin
          if (BUS_REQ.wide) begin
            nxt_q.cr0 = BUS_REQ.wdata;
          end
        end
        ADDR_SECOND_CC: begin
          if (BUS_REQ.wide) begin
            nxt_q.cr1 = BUS_REQ.wdata;
          end
        end
        default: begin
        end
      endcase
    end

    // Run sequencing; stop mode holds the counter at zero
    case (q_ff.run)
      RUN_IDLE: begin
        nxt_q.cnt = COUNTER_RST;
        if (running) begin
          nxt_q.run = (q_ff.mode == MODE_CLR_EDGE) ? RUN_ARMED : RUN_COUNT;
        end
      end
      RUN_ARMED: begin
        if (!running) begin
          nxt_q.run = RUN_IDLE;
        end else if (valid0) begin
          nxt_q.cnt = COUNTER_RST;
          nxt_q.run = RUN_COUNT;
        end
      end
      RUN_COUNT: begin
        if (!running) begin
          nxt_q.run = RUN_IDLE;
          nxt_q.cnt = COUNTER_RST;
        end else if (q_ff.mode == MODE_CLR_EDGE && valid0) begin
          nxt_q.cnt = COUNTER_RST;
        end else if (tick) begin
          if (clr_match && eq0) begin
            nxt_q.cnt = COUNTER_RST;
          end else begin
            nxt_q.cnt = q_ff.cnt + 16'h0001;
          end
          if (wrap) begin
            nxt_q.ovf = 1'b1;
          end
        end
      end
      default: begin
        nxt_q.run = RUN_IDLE;
      end
    endcase

    // Match requests fire once as equality begins
    nxt_q.eq0_prev = eq0;
    nxt_q.eq1_prev = eq1;
    nxt_q.irq0     = eq0 & ~q_ff.eq0_prev;
    nxt_q.irq1     = eq1 & ~q_ff.eq1_prev;

    // Captures override any write in the same cycle
    if (!first_cmp && trig0) begin
      nxt_q.cr0 = q_ff.cnt;
    end
    if (!second_cmp && valid0) begin
      nxt_q.cr1 = q_ff.cnt;
    end

    // Read path
    if (BUS_REQ.rd) begin
      case (BUS_REQ.addr)
        ADDR_CLK_SEL:   nxt_q.rdata = {8'h00, q_ff.clk_sel};
        ADDR_MODE_CTRL: nxt_q.rdata = {12'h000, q_ff.mode, q_ff.ovf};
        ADDR_CC_CTRL:   nxt_q.rdata = {13'h0000, q_ff.cc_ctrl};
        ADDR_FIRST_CC:  nxt_q.rdata = q_ff.cr0;
        ADDR_SECOND_CC: nxt_q.rdata = q_ff.cr1;
        ADDR_COUNTER: begin
          // Counter value is returned directly, valid even on pin clock
          nxt_q.rdata = q_ff.cnt;
          if (!second_cmp) begin
            nxt_q.cr1 = q_ff.cnt;
          end
        end
        default:        nxt_q.rdata = 16'h0000;
      endcase
    end

    nxt_q.clkout = q_ff.clk_sel[CLKOUT_EN_BIT] & out_src;
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      q_ff.clk_sel  <= CLK_SEL_RST;
      q_ff.mode     <= MODE_STOP;
      q_ff.ovf      <= OVF_RST;
      q_ff.cc_ctrl  <= CC_CTRL_RST;
      q_ff.cr0      <= CC_RST;
      q_ff.cr1      <= CC_RST;
      q_ff.cnt      <= COUNTER_RST;
      q_ff.run      <= RUN_IDLE;
      q_ff.eq0_prev <= 1'b0;
      q_ff.eq1_prev <= 1'b0;
      q_ff.irq0     <= 1'b0;
      q_ff.irq1     <= 1'b0;
      q_ff.rdata    <= 16'h0000;
      q_ff.clkout   <= 1'b0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign BUS_RDATA              = q_ff.rdata;
  assign FIRST_MATCH_IRQ        = q_ff.irq0;
  assign SECOND_MATCH_IRQ       = q_ff.irq1;
  assign PROGRAMMABLE_CLOCK_OUT = q_ff.clkout;

endmodule : timer16_core

`default_nettype wire

// ### tb/timer16_props.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Port checker
// ****************************************************************
module timer16_props (
  input  wire logic                  CLOCK,
  input  wire logic                  RST,
  input  wire timer16_pkg::cpu_req_s BUS_REQ,
  input  wire logic [15:0]           BUS_RDATA,
  input  wire logic                  FIRST_MATCH_IRQ,
  input  wire logic                  SECOND_MATCH_IRQ,
  input  wire logic                  PROGRAMMABLE_CLOCK_OUT
);
  import timer16_pkg::*;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  logic wr_sel;
  logic wr_mode;
  logic rd_gap;
  assign wr_sel  = BUS_REQ.wr && BUS_REQ.addr == ADDR_CLK_SEL;
  assign wr_mode = BUS_REQ.wr && BUS_REQ.addr == ADDR_MODE_CTRL;
  // Only decoded places may answer a read with data
  assign rd_gap  = BUS_REQ.rd && !(BUS_REQ.addr inside {ADDR_CLK_SEL,
                   ADDR_MODE_CTRL, ADDR_CC_CTRL, ADDR_FIRST_CC,
                   ADDR_SECOND_CC, ADDR_COUNTER});
  AST_FIRST_IRQ_PULSE: assert property (
    FIRST_MATCH_IRQ |=> !FIRST_MATCH_IRQ)
    else $error("first match request longer than one cycle");
  AST_SECOND_IRQ_PULSE: assert property (
    SECOND_MATCH_IRQ |=> !SECOND_MATCH_IRQ)
    else $error("second match request longer than one cycle");
  AST_MODE_UPPER_ZERO: assert property (
    BUS_REQ.rd && BUS_REQ.addr == ADDR_MODE_CTRL
    |=> BUS_RDATA[15:4] == 12'h000)
    else $error("mode register upper bits not zero");
  AST_SEL_UPPER_ZERO: assert property (
    BUS_REQ.rd && BUS_REQ.addr == ADDR_CLK_SEL |=> BUS_RDATA[15:8] == 8'h00)
    else $error("clock select read has upper bits set");
  AST_GAP_READ_ZERO: assert property (
    rd_gap |=> BUS_RDATA == 16'h0000)
    else $error("unmapped read returned data");
  AST_RDATA_HOLD: assert property (
    !BUS_REQ.rd |=> $stable(BUS_RDATA))
    else $error("read data changed without a read");
  AST_CLKOUT_OFF: assert property (
    wr_sel && !BUS_REQ.wdata[CLKOUT_EN_BIT] ##1 (!wr_sel)[*3]
    |-> !PROGRAMMABLE_CLOCK_OUT)
    else $error("clock output active while disabled");
  AST_CLKOUT_FXX: assert property (
    wr_sel && BUS_REQ.wdata[7:0] == 8'h85 ##1 (!wr_sel)[*4]
    |-> PROGRAMMABLE_CLOCK_OUT != $past(PROGRAMMABLE_CLOCK_OUT))
    else $error("clock output not toggling at fxx");
  AST_STOP_QUIET: assert property (
    wr_mode && BUS_REQ.wdata[3:1] == 3'h0 ##1 (!wr_mode)[*4]
    |-> !FIRST_MATCH_IRQ && !SECOND_MATCH_IRQ)
    else $error("match request while stopped");
endmodule : timer16_props
bind timer16_core timer16_props chk (
  .CLOCK(CLOCK), .RST(RST), .BUS_REQ(BUS_REQ), .BUS_RDATA(BUS_RDATA),
  .FIRST_MATCH_IRQ(FIRST_MATCH_IRQ), .SECOND_MATCH_IRQ(SECOND_MATCH_IRQ),
  .PROGRAMMABLE_CLOCK_OUT(PROGRAMMABLE_CLOCK_OUT));
`default_nettype wire

// ### tb/timer16_pins.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Pin-side partner
// ****************************************************************
module timer16_pins (
  input  wire logic CLOCK,
  output var  logic PRI,
  output var  logic SEC,
  output var  logic SUB,
  output var  logic WATCH
);
  // Slow clock runs free, unrelated in phase to CLOCK
  initial begin
    {PRI, SEC, WATCH, SUB} = 4'h0;
    forever #610 SUB = ~SUB;
  end
  task automatic set_pin(input logic p, input logic v);
    if (p) SEC = v;
    else PRI = v;
  endtask : set_pin
  // Watch tick is a same-clock one-cycle pulse
  task automatic tick();
    @(posedge CLOCK);
    #2 WATCH = 1'b1;
    @(posedge CLOCK);
    #2 WATCH = 1'b0;
  endtask : tick
endmodule : timer16_pins
`default_nettype wire

// ### tb/timer16_capture_compare_core_test.sv
`timescale 1ns/100ps
`default_nettype none
module timer16_capture_compare_core_test;
  import timer16_pkg::*;
  logic        clock, rst, pri, sec, sub, watch, irq1, irq2, pclk, lastp;
  logic [1:0]  es0, es1;
  logic [15:0] rdata, v, w;
  cpu_req_s    req;
  int          err_count, n_checks, t;
  int          cycles = 0;
  timer16_core dut (.CLOCK(clock), .RST(rst), .BUS_REQ(req),
    .BUS_RDATA(rdata), .PRIMARY_TIMER_INPUT(pri),
    .SECONDARY_TIMER_INPUT(sec), .SUBSYSTEM_CLOCK(sub),
    .WATCH_TICK_SOURCE(watch), .EDGE_SEL_PIN0(es0), .EDGE_SEL_PIN1(es1),
    .FIRST_MATCH_IRQ(irq1), .SECOND_MATCH_IRQ(irq2),
    .PROGRAMMABLE_CLOCK_OUT(pclk));
  timer16_pins pins (.CLOCK(clock), .PRI(pri), .SEC(sec), .SUB(sub),
    .WATCH(watch));
  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic stop_test();
    if (err_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask : cyc
  // One idle cycle after each access keeps req single-driven per step
  task automatic acc(input logic wr, rd, input logic [15:0] a, d,
                     input logic wd);
    req = '{addr: a, wdata: d, wr: wr, rd: rd, wide: wd};
    cyc(1);
    req = '0;
    cyc(1);
  endtask : acc
  task automatic wr(input logic [15:0] a, d);
    acc(1'b1, 1'b0, a, d, 1'b1);
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    req = '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1, wide: 1'b1};
    cyc(1);
    d = rdata;
    req = '0;
    cyc(1);
  endtask : rd
  task automatic chk(input string n, input logic [15:0] e, g);
    n_checks++;
    if (g !== e) begin
      $display("mismatch %s exp %h got %h", n, e, g);
      err_count++;
    end
  endtask : chk
  task automatic rng(input string n, input logic [15:0] lo, hi, g);
    n_checks++;
    if (!(g >= lo && g <= hi)) begin
      $display("mismatch %s exp %h..%h got %h", n, lo, hi, g);
      err_count++;
    end
  endtask : rng
  task automatic restart(input logic [15:0] sel, mode);
    wr(ADDR_MODE_CTRL, 16'h0000);
    wr(ADDR_CLK_SEL, sel);
    wr(ADDR_MODE_CTRL, mode);
  endtask : restart
  task automatic wait_irq(input logic second);
    t = 0;
    while ((second ? irq2 : irq1) !== 1'b1 && t < 300) begin
      cyc(1);
      t++;
    end
    // A request that never comes is a failure, not a silent skip
    if (t >= 300) begin
      $display("mismatch irq_wait exp 1 got 0");
      err_count++;
    end
  endtask : wait_irq
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs();
    rd(ADDR_CLK_SEL, v);
    chk("clk_sel", 16'h0000, v);
    rd(ADDR_COUNTER, v);
    chk("counter", 16'h0000, v);
    rd(16'hff00, v);
    chk("unmapped", 16'h0000, v);
    wr(ADDR_MODE_CTRL, 16'h00ff);
    rd(ADDR_MODE_CTRL, v);
    chk("mode_rd", 16'h000f, v);
    wr(ADDR_MODE_CTRL, 16'h0000);
    rd(ADDR_MODE_CTRL, v);
    chk("mode_clr", 16'h0000, v);
    wr(ADDR_FIRST_CC, 16'h1234);
    acc(1'b1, 1'b0, ADDR_FIRST_CC, 16'h00ff, 1'b0);
    rd(ADDR_FIRST_CC, v);
    chk("byte_wr", 16'h1234, v);
  endtask : t_regs
  task automatic t_rate();
    // Doubled clock (code 1) is never chosen at this clock rate
    for (int i = 2; i < 5; i++) begin
      restart(16'(i << 4), 16'h0006);
      rd(ADDR_COUNTER, v);
      cyc(38);
      rd(ADDR_COUNTER, w);
      chk("rate", 16'(20 >> (i - 2)), w - v);
    end
    wr(ADDR_MODE_CTRL, 16'h0000);
    cyc(4);
    rd(ADDR_COUNTER, v);
    chk("stop_clr", 16'h0000, v);
    cyc(10);
    rd(ADDR_COUNTER, v);
    chk("stop_hold", 16'h0000, v);
  endtask : t_rate
  task automatic t_match();
    wr(ADDR_MODE_CTRL, 16'h0000);
    wr(ADDR_CC_CTRL, 16'h0000);
    wr(ADDR_FIRST_CC, 16'h0020);
    wr(ADDR_SECOND_CC, 16'h0030);
    restart(16'h0020, 16'h0006);
    wait_irq(1'b0);
    wait_irq(1'b1);
    chk("match_gap", 16'd32, 16'(t));
    wr(ADDR_MODE_CTRL, 16'h0000);
    wr(ADDR_FIRST_CC, 16'h0009);
    wr(ADDR_MODE_CTRL, 16'h000c);
    wait_irq(1'b0);
    cyc(1);
    wait_irq(1'b0);
    chk("clr_period", 16'd19, 16'(t));
  endtask : t_match
  task automatic t_capture();
    wr(ADDR_MODE_CTRL, 16'h0000);
    wr(ADDR_CC_CTRL, 16'h0005);
    restart(16'h0020, 16'h0006);
    rd(ADDR_COUNTER, v);
    rd(ADDR_SECOND_CC, w);
    chk("ctr_via_cc2", v, w);
    rd(ADDR_COUNTER, v);
    pins.set_pin(1'b0, 1'b1);
    cyc(8);
    rd(ADDR_SECOND_CC, w);
    rng("cc2_capture", v + 16'd1, v + 16'd8, w);
    rd(ADDR_COUNTER, v);
    pins.set_pin(1'b0, 1'b0);
    cyc(8);
    rd(ADDR_FIRST_CC, w);
    rng("cc1_pin0", v + 16'd1, v + 16'd8, w);
    wr(ADDR_MODE_CTRL, 16'h0000);
    wr(ADDR_CC_CTRL, 16'h0007);
    wr(ADDR_MODE_CTRL, 16'h0006);
    cyc(4);
    rd(ADDR_COUNTER, v);
    pins.set_pin(1'b1, 1'b1);
    cyc(8);
    rd(ADDR_FIRST_CC, w);
    rng("cc1_pin1", v + 16'd1, v + 16'd8, w);
  endtask : t_capture
  task automatic t_sources();
    restart(16'h0000, 16'h0006);
    repeat (3) begin
      pins.set_pin(1'b0, 1'b1);
      cyc(4);
      pins.set_pin(1'b0, 1'b0);
      cyc(4);
    end
    rd(ADDR_COUNTER, v);
    chk("pin_count", 16'd3, v);
    restart(16'h0070, 16'h0006);
    cyc(2);
    repeat (4) pins.tick();
    cyc(2);
    rd(ADDR_COUNTER, v);
    chk("watch_count", 16'd4, v);
  endtask : t_sources
  task automatic t_edge_start();
    restart(16'h0020, 16'h000a);
    cyc(10);
    rd(ADDR_COUNTER, v);
    chk("armed", 16'h0000, v);
    pins.set_pin(1'b0, 1'b1);
    cyc(30);
    // Falling edge is not the valid edge here and must not clear
    pins.set_pin(1'b0, 1'b0);
    cyc(30);
    rd(ADDR_COUNTER, v);
    rng("edge_run", 16'd20, 16'd40, v);
    pins.set_pin(1'b0, 1'b1);
    cyc(8);
    rd(ADDR_COUNTER, v);
    rng("edge_clr", 16'd1, 16'd8, v);
    pins.set_pin(1'b0, 1'b0);
  endtask : t_edge_start
  task automatic t_clkout();
    wr(ADDR_MODE_CTRL, 16'h0000);
    for (int c = 0; c < 13; c++) begin
      if (c != 0 && c < 5) continue;
      // Source first, then the enable, as software must
      wr(ADDR_CLK_SEL, 16'(c));
      wr(ADDR_CLK_SEL, 16'(8'h80 | c));
      cyc(6);
      t = 0;
      lastp = pclk;
      repeat (256) begin
        cyc(1);
        if (pclk !== lastp) t++;
        lastp = pclk;
      end
      if (c == 0) rng("sub_out", 16'd1, 16'd255, 16'(t));
      else chk("div_out", 16'(256 >> (c - 5)), 16'(t));
    end
    wr(ADDR_CLK_SEL, 16'h0005);
    cyc(4);
    chk("out_off", 16'h0000, {15'h0, pclk});
  endtask : t_clkout
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      stop_test();
    end
  end
  initial begin
    rst = 1'b1;
    req = '0;
    es0 = 2'b01;
    es1 = 2'b01;
    err_count = 0;
    n_checks = 0;
    repeat (5) @(posedge clock);
    #2 rst = 1'b0;
    t_regs();
    t_rate();
    t_match();
    t_capture();
    t_sources();
    t_edge_start();
    t_clkout();
    stop_test();
  end
endmodule : timer16_capture_compare_core_test
`default_nettype wire
